// file: dppt_pkg.sv
package dppt_pkg;
	// Register offsets (byte addresses, one register every 4 bytes)
	localparam logic [7:0] DPPT_ADDR_CTRL = 8'h00;
	localparam logic [7:0] DPPT_ADDR_HIGH = 8'h04;
	localparam logic [7:0] DPPT_ADDR_LOW = 8'h08;
	localparam logic [7:0] DPPT_ADDR_ON = 8'h0C;
	localparam logic [7:0] DPPT_ADDR_CLKPER = 8'h10;
	localparam logic [7:0] DPPT_ADDR_FRZ_SET = 8'h14;
	localparam logic [7:0] DPPT_ADDR_FRZ_CLR = 8'h18;
	localparam logic [7:0] DPPT_ADDR_IRQ_STAT = 8'h1C;
	localparam logic [7:0] DPPT_ADDR_IRQ_MASK = 8'h20;
	// Control register fields
	localparam int DPPT_CTRL_RUN = 0;
	localparam int DPPT_CTRL_SEL = 1;
	localparam int DPPT_CTRL_PRE = 2;
	localparam int DPPT_CTRL_BURST = 3;
	// Peripheral clock register fields
	localparam int DPPT_CLK_GATE = 0;
	localparam int DPPT_CLK_DIV_LSB = 1;
	// Reset values
	localparam logic [15:0] DPPT_RELOAD_RST = 16'h0000;
	localparam logic [3:0] DPPT_CTRL_RST = 4'h0;
	// Timing
	localparam int DPPT_CLK_HZ = 50000000;
	localparam int DPPT_SLOW_HZ = 32768;
	localparam int DPPT_FAST_HZ = 16000000;
	localparam int DPPT_PRESCALE = 10;
	localparam int DPPT_SLOW_DIV = DPPT_CLK_HZ / DPPT_SLOW_HZ;
	localparam int DPPT_FAST_DIV = DPPT_CLK_HZ / DPPT_FAST_HZ;
	localparam logic [10:0] DPPT_SLOW_LAST = 11'(DPPT_SLOW_DIV - 1);
	localparam logic [3:0] DPPT_PRE_LAST = 4'(DPPT_PRESCALE - 1);

	typedef enum logic [1:0]
	{
		DPPT_IDLE = 2'b00,
		DPPT_HIGH = 2'b01,
		DPPT_LOW = 2'b10
	} dppt_state_t;

	typedef struct packed
	{
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} dppt_bus_t;
endpackage

// file: dppt_timer.sv
// Functional notes
// [R1] Counters and reloads reset to zero, 16 bits
// [R2] Clock selectable 16/8/4/2 MHz or 32 kHz
// [R3] Fast clock needs select bit and gate
// [R4] Prescale divides on-period counter by ten
// [R5] Period is (high+1)+(low+1) timer clocks
// [R6] Run loads counters and raises cycle interrupt
// [R7] Phase counter alternates high/low shadow at zero
// [R8] True output high in high phase, inverse
// [R9] Burst mode: half-rate clock during high phase
// [R10] On counter waits; cycle end raises interrupt
// [R11] Cycle end reloads counters and both shadows
// [R12] Shadows update only at cycle end; code also loads them at start
// [R13] Interrupt issued on start, status set two clocks later
// [R14] Disabled timer held reset except software registers and interrupt status
// [R15] On-period address reads live on counter
// [R16] Phase addresses read live phase counter
// [R17] Freeze set/clear stops and resumes counting
// [R18] Cycle event is one system-clock pulse
// [R19] Clock selection built as enable strobes
module dppt_timer
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic nrst_i,
	// Register port
	input wire dppt_pkg::dppt_bus_t bus_i,
	output logic [15:0] rdata_o,
	// Outputs
	output logic pwm_out_true_o,
	output logic pwm_out_inverted_o,
	output logic timer_cycle_irq_o
);
	import dppt_pkg::*;

	default clocking dppt_cb @(posedge clock_i);
	endclocking
	default disable iff (!nrst_i);

	logic [3:0] ctrl_q;
	logic [2:0] clkper_q;
	logic [15:0] high_reload_q, low_reload_q, on_reload_q;
	logic [15:0] high_shadow_q, low_shadow_q;
	logic [15:0] phase_cnt_q, phase_cnt_d, on_cnt_q, on_cnt_d;
	dppt_state_t state_q, state_d;
	logic freeze_q, irq_stat_q, irq_mask_q, irq_q;
	logic [15:0] rdata_q;
	logic [10:0] slow_cnt_q;
	logic [1:0] fast_cnt_q;
	logic [3:0] fast_sub_q;
	logic [3:0] pre_cnt_q;
	logic burst_q, pwm_q, npwm_q, cycle_pulse_q;

	wire run = ctrl_q[DPPT_CTRL_RUN];
	wire burst_mode = ctrl_q[DPPT_CTRL_BURST];
	wire wr_ctrl = bus_i.wr && bus_i.addr == DPPT_ADDR_CTRL;
	wire wr_high = bus_i.wr && bus_i.addr == DPPT_ADDR_HIGH;
	wire wr_low = bus_i.wr && bus_i.addr == DPPT_ADDR_LOW;
	wire wr_on = bus_i.wr && bus_i.addr == DPPT_ADDR_ON;
	wire wr_clkper = bus_i.wr && bus_i.addr == DPPT_ADDR_CLKPER;
	wire wr_fset = bus_i.wr && bus_i.addr == DPPT_ADDR_FRZ_SET;
	wire wr_fclr = bus_i.wr && bus_i.addr == DPPT_ADDR_FRZ_CLR;
	wire wr_stat = bus_i.wr && bus_i.addr == DPPT_ADDR_IRQ_STAT;
	wire wr_mask = bus_i.wr && bus_i.addr == DPPT_ADDR_IRQ_MASK;

	// Timer clock strobes, one system domain
	wire fast_sel = ctrl_q[DPPT_CTRL_SEL] && clkper_q[DPPT_CLK_GATE]; // [R3]
	wire [1:0] fast_div = clkper_q[DPPT_CLK_DIV_LSB +: 2];
	wire slow_tick = slow_cnt_q == DPPT_SLOW_LAST;
	wire fast_base = fast_cnt_q == 2'(DPPT_FAST_DIV - 1);
	wire [3:0] fast_mask = 4'((4'h1 << fast_div) - 4'h1);
	wire fast_tick = fast_base && ((fast_sub_q & fast_mask) == 4'h0);
	wire tick = fast_sel ? fast_tick : slow_tick; // [R2] [R19]
	wire pre_en = ctrl_q[DPPT_CTRL_PRE];
	wire on_tick = tick && (!pre_en || pre_cnt_q == DPPT_PRE_LAST); // [R4]
	wire adv = run && !freeze_q && tick; // [R17]
	wire on_adv = run && !freeze_q && on_tick; // [R17]

	// Cycle end: both counters zero while low phase counting
	wire starting = run && state_q == DPPT_IDLE; // [R6] [R13]
	wire cycle_end = adv && state_q == DPPT_LOW && phase_cnt_q == 16'h0000
		&& on_cnt_q == 16'h0000; // [R10]

	always_comb
	begin
		state_d = state_q;
		phase_cnt_d = phase_cnt_q;
		on_cnt_d = on_cnt_q;
		if (!run)
		begin
			state_d = DPPT_IDLE; // [R14]
			phase_cnt_d = 16'h0000;
			on_cnt_d = 16'h0000;
		end
		else if (starting)
		begin
			state_d = DPPT_HIGH; // [R6]
			phase_cnt_d = high_reload_q;
			on_cnt_d = on_reload_q;
		end
		else
		begin
			if (cycle_end)
			begin
				state_d = DPPT_HIGH; // [R11]
				phase_cnt_d = high_reload_q;
			end
			else if (adv)
			begin
				if (phase_cnt_q != 16'h0000)
					phase_cnt_d = phase_cnt_q - 16'h0001;
				else if (state_q == DPPT_HIGH)
				begin
					state_d = DPPT_LOW; // [R7] [R5]
					phase_cnt_d = low_shadow_q;
				end
				else
				begin
					state_d = DPPT_HIGH; // [R7]
					phase_cnt_d = high_shadow_q;
				end
			end
			if (cycle_end)
				on_cnt_d = on_reload_q; // [R11]
			else if (on_adv && on_cnt_q != 16'h0000)
				on_cnt_d = on_cnt_q - 16'h0001; // [R10]
		end
	end

	wire shadow_load = starting || cycle_end; // [R12]
	wire cycle_evt = starting || cycle_end;
	wire high_phase = state_q == DPPT_HIGH;
	wire pwm_level = high_phase && (!burst_mode || burst_q); // [R8] [R9]
	wire [15:0] rd_mux =
		(bus_i.addr == DPPT_ADDR_CTRL) ? {12'h000, ctrl_q} :
		(bus_i.addr == DPPT_ADDR_HIGH) ? phase_cnt_q : // [R16]
		(bus_i.addr == DPPT_ADDR_LOW) ? phase_cnt_q : // [R16]
		(bus_i.addr == DPPT_ADDR_ON) ? on_cnt_q : // [R15]
		(bus_i.addr == DPPT_ADDR_CLKPER) ? {13'h0000, clkper_q} :
		(bus_i.addr == DPPT_ADDR_FRZ_SET) ? {15'h0000, freeze_q} :
		(bus_i.addr == DPPT_ADDR_IRQ_STAT) ? {15'h0000, irq_stat_q} :
		(bus_i.addr == DPPT_ADDR_IRQ_MASK) ? {15'h0000, irq_mask_q} :
		16'h0000;

	// Software registers, kept while disabled
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ctrl_q <= DPPT_CTRL_RST;
			clkper_q <= 3'h0;
			high_reload_q <= DPPT_RELOAD_RST; // [R1]
			low_reload_q <= DPPT_RELOAD_RST;
			on_reload_q <= DPPT_RELOAD_RST;
			freeze_q <= 1'b0;
			irq_mask_q <= 1'b0;
			rdata_q <= 16'h0000;
		end
		else
		begin
			if (wr_ctrl)
				ctrl_q <= bus_i.wdata[3:0];
			if (wr_clkper)
				clkper_q <= bus_i.wdata[2:0];
			if (wr_high)
				high_reload_q <= bus_i.wdata;
			if (wr_low)
				low_reload_q <= bus_i.wdata;
			if (wr_on)
				on_reload_q <= bus_i.wdata;
			if (wr_fset && bus_i.wdata[0])
				freeze_q <= 1'b1; // [R17]
			else if (wr_fclr && bus_i.wdata[0])
				freeze_q <= 1'b0; // [R17]
			if (wr_mask)
				irq_mask_q <= bus_i.wdata[0];
			rdata_q <= bus_i.rd ? rd_mux : 16'h0000;
		end
	end

	// Counting logic, held in reset while not running
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_q <= DPPT_IDLE;
			phase_cnt_q <= DPPT_RELOAD_RST; // [R1]
			on_cnt_q <= DPPT_RELOAD_RST;
			high_shadow_q <= DPPT_RELOAD_RST;
			low_shadow_q <= DPPT_RELOAD_RST;
		end
		else
		begin
			state_q <= state_d;
			phase_cnt_q <= phase_cnt_d;
			on_cnt_q <= on_cnt_d;
			if (!run)
			begin
				high_shadow_q <= DPPT_RELOAD_RST; // [R14]
				low_shadow_q <= DPPT_RELOAD_RST;
			end
			else if (shadow_load)
			begin
				high_shadow_q <= high_reload_q; // [R11] [R12]
				low_shadow_q <= low_reload_q;
			end
		end
	end

	// Strobe generators
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			slow_cnt_q <= 11'h000;
			fast_cnt_q <= 2'h0;
			fast_sub_q <= 4'h0;
			pre_cnt_q <= 4'h0;
			burst_q <= 1'b0;
		end
		else if (!run)
		begin
			slow_cnt_q <= 11'h000; // [R14]
			fast_cnt_q <= 2'h0;
			fast_sub_q <= 4'h0;
			pre_cnt_q <= 4'h0;
			burst_q <= 1'b0;
		end
		else
		begin
			slow_cnt_q <= slow_tick ? 11'h000 : slow_cnt_q + 11'h001;
			fast_cnt_q <= fast_base ? 2'h0 : fast_cnt_q + 2'h1;
			if (fast_base)
				fast_sub_q <= fast_sub_q + 4'h1;
			if (tick && !freeze_q)
			begin
				burst_q <= !burst_q; // [R9]
				if (pre_en)
					pre_cnt_q <= (pre_cnt_q == DPPT_PRE_LAST) ? 4'h0 :
						pre_cnt_q + 4'h1; // [R4]
			end
		end
	end

	// Outputs and interrupt
	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pwm_q <= 1'b0;
			npwm_q <= 1'b1;
			cycle_pulse_q <= 1'b0;
			irq_stat_q <= 1'b0;
			irq_q <= 1'b0;
		end
		else
		begin
			pwm_q <= run && pwm_level; // [R8]
			npwm_q <= !(run && pwm_level); // [R8]
			cycle_pulse_q <= cycle_evt; // [R18]
			if (cycle_pulse_q)
				irq_stat_q <= 1'b1; // [R13]
			else if (wr_stat && bus_i.wdata[0])
				irq_stat_q <= 1'b0;
			irq_q <= run && irq_stat_q && irq_mask_q; // [R14]
		end
	end

	assign rdata_o = rdata_q;
	assign pwm_out_true_o = pwm_q;
	assign pwm_out_inverted_o = npwm_q;
	assign timer_cycle_irq_o = irq_q;

	// Tick counts per phase, for the period checks
	logic [15:0] hi_ticks_q, lo_ticks_q;

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			hi_ticks_q <= 16'h0000;
		else if (state_q != DPPT_HIGH)
			hi_ticks_q <= 16'h0000;
		else if (adv && phase_cnt_q != 16'h0000)
			hi_ticks_q <= hi_ticks_q + 16'h0001;
	end

	always_ff @(posedge clock_i or negedge nrst_i)
	begin
		if (!nrst_i)
			lo_ticks_q <= 16'h0000;
		else if (state_q != DPPT_LOW)
			lo_ticks_q <= 16'h0000;
		else if (adv && phase_cnt_q != 16'h0000)
			lo_ticks_q <= lo_ticks_q + 16'h0001;
	end

	AST_INV_OUT: assert property // [R8]
		(pwm_out_inverted_o == !pwm_out_true_o)
		else $error("inverted output not inverse");
	AST_START_IRQ: assert property // [R13]
		(starting |-> ##2 irq_stat_q)
		else $error("no interrupt on start");
	AST_START_LOAD: assert property // [R6]
		(starting |=> phase_cnt_q == $past(high_reload_q)
		&& on_cnt_q == $past(on_reload_q))
		else $error("start load wrong");
	AST_DISABLED: assert property // [R14]
		(!run |=> phase_cnt_q == 16'h0000 && on_cnt_q == 16'h0000
		&& state_q == DPPT_IDLE)
		else $error("counters not held while disabled");
	AST_DIS_OUT: assert property // [R14]
		(!run |=> !pwm_out_true_o && pwm_out_inverted_o
		&& !timer_cycle_irq_o)
		else $error("outputs not held while disabled");
	AST_FREEZE: assert property // [R17]
		((freeze_q && run && !starting) |=> $stable(phase_cnt_q)
		&& $stable(on_cnt_q))
		else $error("counter moved while frozen");
	AST_SHADOW: assert property // [R12]
		((run && !shadow_load) |=> $stable(high_shadow_q)
		&& $stable(low_shadow_q))
		else $error("shadow changed mid cycle");
	AST_SHADOW_LOAD: assert property // [R11]
		(shadow_load |=> high_shadow_q == $past(high_reload_q)
		&& low_shadow_q == $past(low_reload_q))
		else $error("shadows not loaded at cycle end");
	AST_PULSE: assert property // [R18]
		(cycle_pulse_q |=> !cycle_pulse_q)
		else $error("cycle pulse longer than one clock");
	AST_STAT_SET: assert property // [R18]
		(cycle_pulse_q |=> irq_stat_q)
		else $error("cycle event not recorded");
	AST_TOGGLE: assert property // [R7]
		((adv && !cycle_end && !starting && state_q == DPPT_HIGH
		&& phase_cnt_q == 16'h0000) |=> state_q == DPPT_LOW
		&& phase_cnt_q == $past(low_shadow_q))
		else $error("phase did not toggle");
	AST_HIGH_LEN: assert property // [R5]
		((adv && state_q == DPPT_HIGH && phase_cnt_q == 16'h0000)
		|-> hi_ticks_q == high_shadow_q)
		else $error("high phase length wrong");
	AST_LOW_LEN: assert property // [R5]
		((adv && state_q == DPPT_LOW && phase_cnt_q == 16'h0000)
		|-> lo_ticks_q == low_shadow_q)
		else $error("low phase length wrong");
	AST_CYCLE_RELOAD: assert property // [R11]
		(cycle_end |=> state_q == DPPT_HIGH
		&& phase_cnt_q == $past(high_reload_q)
		&& on_cnt_q == $past(on_reload_q))
		else $error("cycle end reload wrong");
	AST_ON_HOLD: assert property // [R10]
		((run && !starting && on_cnt_q == 16'h0000 && !cycle_end)
		|=> on_cnt_q == 16'h0000)
		else $error("on counter left zero early");
	AST_ON_STEP: assert property // [R4]
		((run && !starting && !cycle_end && !on_tick)
		|=> $stable(on_cnt_q))
		else $error("on counter moved without its strobe");
	AST_PWM_HIGH: assert property // [R8]
		((run && high_phase && !burst_mode) |=> pwm_out_true_o)
		else $error("true output low in high phase");
	AST_PWM_LOW: assert property // [R8]
		((run && !high_phase) |=> !pwm_out_true_o)
		else $error("true output high outside high phase");
	AST_BURST: assert property // [R9]
		((run && burst_mode && high_phase)
		|=> pwm_out_true_o == $past(burst_q))
		else $error("burst output does not follow half rate");
	AST_READ_ON: assert property // [R15]
		((bus_i.rd && bus_i.addr == DPPT_ADDR_ON)
		|=> rdata_o == $past(on_cnt_q))
		else $error("on address not live counter");
	AST_READ_PHASE: assert property // [R16]
		((bus_i.rd && (bus_i.addr == DPPT_ADDR_HIGH
		|| bus_i.addr == DPPT_ADDR_LOW))
		|=> rdata_o == $past(phase_cnt_q))
		else $error("phase address not live counter");

	CV_CYCLE: cover property
		(cycle_end);
	CV_BURST: cover property
		(burst_mode && pwm_q ##3 !pwm_q ##3 pwm_q);
	CV_FREEZE: cover property
		(freeze_q && run);
	CV_PRESCALE: cover property
		(pre_en && on_adv);
	CV_FAST_DIV: cover property
		(fast_sel && fast_div != 2'h0 && tick);
endmodule

// file: dppt_timer_tb_top.sv
module dppt_timer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import dppt_pkg::*;
	logic clock_i;
	logic nrst_i;
	dppt_bus_t bus;
	logic [15:0] rdata;
	logic pwm_t;
	logic pwm_n;
	logic irq;
	logic [15:0] a;
	logic [15:0] b;
	int failures;
	int n_compared;

	dppt_timer i_dppt_timer
	(
		.clock_i(clock_i),
		.nrst_i(nrst_i),
		.bus_i(bus),
		.rdata_o(rdata),
		.pwm_out_true_o(pwm_t),
		.pwm_out_inverted_o(pwm_n),
		.timer_cycle_irq_o(irq)
	);

	initial
	begin
		clock_i = 1'b0;
		forever #10 clock_i = ~clock_i;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
		#1;
	endtask

	task automatic wr(input logic [7:0] ad, input logic [15:0] d);
		@(posedge clock_i);
		bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clock_i);
		bus.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] ad, output logic [15:0] d);
		@(posedge clock_i);
		bus <= '{addr: ad, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
		@(posedge clock_i);
		bus.rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// Length of one high stretch and the low stretch after it, in clocks
	task automatic meas(output logic [15:0] hi, output logic [15:0] lo);
		int k;
		hi = 16'h0000;
		lo = 16'h0000;
		for (k = 0; k < 5000 && pwm_t !== 1'b0; k++) tick(1);
		for (k = 0; k < 5000 && pwm_t !== 1'b1; k++) tick(1);
		while (pwm_t === 1'b1 && hi < 16'h1000)
		begin
			check({15'h0000, pwm_n}, 16'h0000);
			hi++;
			tick(1);
		end
		while (pwm_t === 1'b0 && lo < 16'h1000)
		begin
			check({15'h0000, pwm_n}, 16'h0001);
			lo++;
			tick(1);
		end
	endtask

	task automatic t_reset;
		rd(DPPT_ADDR_HIGH, a);
		check(a, DPPT_RELOAD_RST);
		rd(DPPT_ADDR_ON, a);
		check(a, DPPT_RELOAD_RST);
		rd(8'h24, a);
		check(a, 16'h0000);
		check({13'h0000, pwm_t, pwm_n, irq}, 16'h0002);
	endtask

	task automatic t_keep;
		wr(DPPT_ADDR_HIGH, 16'h0002);
		wr(DPPT_ADDR_LOW, 16'h0003);
		wr(DPPT_ADDR_ON, 16'h0100);
		rd(DPPT_ADDR_LOW, a);
		check(a, 16'h0000);
		rd(DPPT_ADDR_ON, a);
		check(a, 16'h0000);
	endtask

	task automatic t_start;
		wr(DPPT_ADDR_CLKPER, 16'h0001);
		wr(DPPT_ADDR_CTRL, 16'h0003);
		tick(8);
		check({15'h0000, irq}, 16'h0000);
		rd(DPPT_ADDR_IRQ_STAT, a);
		check(a & 16'h0001, 16'h0001);
		wr(DPPT_ADDR_IRQ_MASK, 16'h0001);
		tick(3);
		check({15'h0000, irq}, 16'h0001);
	endtask

	task automatic t_period;
		meas(a, b);
		check(a, 16'(3 * DPPT_FAST_DIV));
		check(b, 16'(4 * DPPT_FAST_DIV));
		wr(DPPT_ADDR_HIGH, 16'h0005);
		meas(a, b);
		check(a, 16'(3 * DPPT_FAST_DIV));
	endtask

	task automatic t_freeze;
		wr(DPPT_ADDR_FRZ_SET, 16'h0001);
		rd(DPPT_ADDR_HIGH, a);
		tick(7);
		rd(DPPT_ADDR_LOW, b);
		check(b, a);
		wr(DPPT_ADDR_FRZ_CLR, 16'h0001);
		meas(a, b);
		check(a, 16'(3 * DPPT_FAST_DIV));
	endtask

	task automatic t_burst;
		wr(DPPT_ADDR_CTRL, 16'h000B);
		meas(a, b);
		check(a, 16'(DPPT_FAST_DIV));
		wr(DPPT_ADDR_CTRL, 16'h0003);
	endtask

	task automatic t_stop;
		wr(DPPT_ADDR_CTRL, 16'h0000);
		tick(3);
		wr(DPPT_ADDR_IRQ_STAT, 16'h0001);
		tick(3);
		check({14'h0000, pwm_t, irq}, 16'h0000);
		wr(DPPT_ADDR_CTRL, 16'h0003);
		// First high stretch after start may lose part of a tick
		meas(a, b);
		check(b, 16'(4 * DPPT_FAST_DIV));
		meas(a, b);
		check(a, 16'(6 * DPPT_FAST_DIV));
	endtask

	// Reads 30 clocks apart span exactly ten fast ticks
	task automatic t_prescale;
		wr(DPPT_ADDR_CTRL, 16'h0007);
		rd(DPPT_ADDR_ON, a);
		tick(28);
		rd(DPPT_ADDR_ON, b);
		check(a - b, 16'h0001);
		wr(DPPT_ADDR_CLKPER, 16'h0003);
		meas(a, b);
		check(a, 16'(12 * DPPT_FAST_DIV));
		check(b, 16'(8 * DPPT_FAST_DIV));
	endtask

	task automatic final_report;
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog well beyond the expected run
	initial
	begin
		#400000;
		failures++;
		final_report();
	end

	initial
	begin
		failures = 0;
		n_compared = 0;
		nrst_i = 1'b0;
		bus = '0;
		repeat (20) @(posedge clock_i);
		nrst_i <= 1'b1;
		t_reset();
		t_keep();
		t_start();
		t_period();
		t_freeze();
		t_burst();
		t_stop();
		t_prescale();
		final_report();
	end
endmodule
